// File: sjio_pkg.sv
// Package of constants and types for the SRAM boundary-scan output control.
package sjio_pkg;

  // ==========================================================================
  // Instruction register and scan chain layout
  // ==========================================================================
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int DQ_W = 36;
  localparam int IN_W = 71;
  localparam int BSR_LEN = 110;
  localparam int ECHO_POS = 0;
  localparam int ECHO_N_POS = 1;
  localparam int Q_POS = 2;
  localparam int IN_POS = 38;
  localparam int CTRL_POS = 109;
  localparam logic [2:0] IR_CAPTURE = 3'h1;
  localparam logic RESET_CTRL = 1'h0;

  // Instruction codes as loaded through the instruction register.
  typedef enum logic [IR_W-1:0] {
    ins_extest = 3'h0,
    ins_idcode = 3'h1,
    ins_sample_z = 3'h2,
    ins_vendor = 3'h3,
    ins_sample = 3'h4,
    ins_resv_a = 3'h5,
    ins_resv_b = 3'h6,
    ins_bypass = 3'h7
  } sjio_instr_t;

  // Test access port states, Gray coded along the scan paths.
  typedef enum logic [3:0] {
    tap_reset = 4'h0, tap_idle = 4'h1, tap_sel_dr = 4'h3, tap_cap_dr = 4'h2,
    tap_shift_dr = 4'h6, tap_exit1_dr = 4'h7, tap_pause_dr = 4'h5,
    tap_exit2_dr = 4'h4, tap_upd_dr = 4'hc, tap_sel_ir = 4'hd,
    tap_cap_ir = 4'hf, tap_shift_ir = 4'he, tap_exit1_ir = 4'ha,
    tap_pause_ir = 4'hb, tap_exit2_ir = 4'h9, tap_upd_ir = 4'h8
  } sjio_tap_t;

  // One set of output pin values: echo clock pair and read data.
  typedef struct packed {
    logic echo;
    logic echo_n;
    logic [DQ_W-1:0] q;
  } sjio_pins_t;

endpackage

// File: sjio_ctrl.sv
// Boundary-scan instruction decode and output pin control of a sync SRAM.
`timescale 1ns/10ps
// ============================================================================
// ============================================================================
module sjio_ctrl #(
  parameter logic [31:0] ID_VALUE = 32'h0a5a_5001 // Arbitrary value.
) (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Test access port pins.
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out,
  output logic tdo_oe_n_out,
  // SRAM core side, same clock.
  input wire sjio_pkg::sjio_pins_t sram_in,
  input wire logic sram_read_in,
  // Pad readback and input pins, from outside.
  input wire sjio_pkg::sjio_pins_t pad_in,
  input wire logic [sjio_pkg::IN_W-1:0] in_pins_in,
  // Output pins.
  output sjio_pkg::sjio_pins_t pins_out,
  output logic echo_oe_n_out,
  output logic q_oe_n_out
);

  // ==========================================================================
  // Input synchronisers
  // ==========================================================================
  logic [2:0] tap_m, tap_s;
  sjio_pkg::sjio_pins_t pad_m, pad_s;
  logic [sjio_pkg::IN_W-1:0] inp_m, inp_s;
  logic tck_d, tck_rise, tck_fall, tms_s, tdi_s;
  // Pins are asynchronous to clk_in, so each passes two flip-flops first.
  always_ff @(posedge clk_in) begin
    tap_m <= {tck_in, tms_in, tdi_in};
    tap_s <= tap_m;
    tck_d <= tap_s[2];
    pad_m <= pad_in;
    pad_s <= pad_m;
    inp_m <= in_pins_in;
    inp_s <= inp_m;
  end

  // The test clock is sampled; its edges become one-cycle strobes.
  assign tck_rise = tap_s[2] & ~tck_d;
  assign tck_fall = ~tap_s[2] & tck_d;
  assign tms_s = tap_s[1];
  assign tdi_s = tap_s[0];

  // ==========================================================================
  // Test access port state machine
  // ==========================================================================
  sjio_pkg::sjio_tap_t tap, next_tap, tap_step;
  // Standard sixteen-state walk, taken on each test clock rise.
  always_comb begin
    tap_step = tap;
    unique case (tap)
      sjio_pkg::tap_reset: tap_step = tms_s ? sjio_pkg::tap_reset
                                            : sjio_pkg::tap_idle;
      sjio_pkg::tap_idle: tap_step = tms_s ? sjio_pkg::tap_sel_dr
                                           : sjio_pkg::tap_idle;
      sjio_pkg::tap_sel_dr: tap_step = tms_s ? sjio_pkg::tap_sel_ir
                                             : sjio_pkg::tap_cap_dr;
      sjio_pkg::tap_cap_dr: tap_step = tms_s ? sjio_pkg::tap_exit1_dr
                                             : sjio_pkg::tap_shift_dr;
      sjio_pkg::tap_shift_dr: tap_step = tms_s ? sjio_pkg::tap_exit1_dr
                                               : sjio_pkg::tap_shift_dr;
      sjio_pkg::tap_exit1_dr: tap_step = tms_s ? sjio_pkg::tap_upd_dr
                                               : sjio_pkg::tap_pause_dr;
      sjio_pkg::tap_pause_dr: tap_step = tms_s ? sjio_pkg::tap_exit2_dr
                                               : sjio_pkg::tap_pause_dr;
      sjio_pkg::tap_exit2_dr: tap_step = tms_s ? sjio_pkg::tap_upd_dr
                                               : sjio_pkg::tap_shift_dr;
      sjio_pkg::tap_upd_dr: tap_step = tms_s ? sjio_pkg::tap_sel_dr
                                             : sjio_pkg::tap_idle;
      sjio_pkg::tap_sel_ir: tap_step = tms_s ? sjio_pkg::tap_reset
                                             : sjio_pkg::tap_cap_ir;
      sjio_pkg::tap_cap_ir: tap_step = tms_s ? sjio_pkg::tap_exit1_ir
                                             : sjio_pkg::tap_shift_ir;
      sjio_pkg::tap_shift_ir: tap_step = tms_s ? sjio_pkg::tap_exit1_ir
                                               : sjio_pkg::tap_shift_ir;
      sjio_pkg::tap_exit1_ir: tap_step = tms_s ? sjio_pkg::tap_upd_ir
                                               : sjio_pkg::tap_pause_ir;
      sjio_pkg::tap_pause_ir: tap_step = tms_s ? sjio_pkg::tap_exit2_ir
                                               : sjio_pkg::tap_pause_ir;
      sjio_pkg::tap_exit2_ir: tap_step = tms_s ? sjio_pkg::tap_upd_ir
                                               : sjio_pkg::tap_shift_ir;
      sjio_pkg::tap_upd_ir: tap_step = tms_s ? sjio_pkg::tap_sel_dr
                                             : sjio_pkg::tap_idle;
    endcase
    next_tap = tck_rise ? tap_step : tap;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tap <= sjio_pkg::tap_reset;
    end else begin
      tap <= next_tap;
    end
  end

  // ==========================================================================
  // Instruction register
  // ==========================================================================
  logic [sjio_pkg::IR_W-1:0] ir_sh, next_ir_sh;
  sjio_pkg::sjio_instr_t ir, next_ir;
  // Captures the fixed pattern, shifts lsb first, updates on the fall.
  always_comb begin
    next_ir_sh = ir_sh;
    next_ir = ir;
    if (tck_rise && tap == sjio_pkg::tap_cap_ir) begin
      next_ir_sh = sjio_pkg::IR_CAPTURE;
    end else if (tck_rise && tap == sjio_pkg::tap_shift_ir) begin
      next_ir_sh = {tdi_s, ir_sh[sjio_pkg::IR_W-1:1]};
    end
    if (tap == sjio_pkg::tap_reset) begin
      next_ir = sjio_pkg::ins_idcode;
    end else if (tck_fall && tap == sjio_pkg::tap_upd_ir) begin
      next_ir = sjio_pkg::sjio_instr_t'(ir_sh);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ir_sh <= sjio_pkg::IR_CAPTURE;
      ir <= sjio_pkg::ins_idcode;
    end else begin
      ir_sh <= next_ir_sh;
      ir <= next_ir;
    end
  end

  // ==========================================================================
  // Data registers
  // ==========================================================================
  logic sel_bsr, sel_id, upd_en, byp, next_byp;
  logic [sjio_pkg::BSR_LEN-1:0] bsr_sh, next_bsr_sh, bsr_upd, next_bsr_upd;
  logic [sjio_pkg::ID_W-1:0] id_sh, next_id_sh;
  // Codes 011, 101 and 110 fall to bypass, so they never disturb the pins.
  assign sel_bsr = ir inside {sjio_pkg::ins_extest, sjio_pkg::ins_sample,
                              sjio_pkg::ins_sample_z};
  assign sel_id = ir == sjio_pkg::ins_idcode;
  assign upd_en = tck_fall && tap == sjio_pkg::tap_upd_dr &&
                  ir inside {sjio_pkg::ins_extest, sjio_pkg::ins_sample};
  // What the output cells capture, by instruction and SRAM activity.
  function automatic sjio_pkg::sjio_pins_t cap_out(
    input sjio_pkg::sjio_instr_t code, input logic rd,
    input sjio_pkg::sjio_pins_t core, input sjio_pkg::sjio_pins_t pad);
    sjio_pkg::sjio_pins_t v;
    v = pad;
    if (code == sjio_pkg::ins_sample) begin
      v.echo = core.echo;
      v.echo_n = core.echo_n;
      v.q = rd ? core.q : pad.q;
    end
    return v;
  endfunction
  // Capture on the rise in Capture-DR, shift on the rise in Shift-DR.
  always_comb begin
    next_bsr_sh = bsr_sh;
    next_bsr_upd = bsr_upd;
    next_id_sh = id_sh;
    next_byp = byp;
    if (tck_rise && tap == sjio_pkg::tap_cap_dr) begin
      {next_bsr_sh[sjio_pkg::ECHO_POS], next_bsr_sh[sjio_pkg::ECHO_N_POS],
       next_bsr_sh[sjio_pkg::Q_POS +: sjio_pkg::DQ_W]} =
        cap_out(ir, sram_read_in, sram_in, pad_s);
      next_bsr_sh[sjio_pkg::IN_POS +: sjio_pkg::IN_W] = inp_s;
      next_bsr_sh[sjio_pkg::CTRL_POS] = bsr_upd[sjio_pkg::CTRL_POS];
      next_id_sh = ID_VALUE;
      next_byp = 1'h0;
    end else if (tck_rise && tap == sjio_pkg::tap_shift_dr) begin
      if (sel_bsr) begin
        next_bsr_sh = {tdi_s, bsr_sh[sjio_pkg::BSR_LEN-1:1]};
      end else if (sel_id) begin
        next_id_sh = {tdi_s, id_sh[sjio_pkg::ID_W-1:1]};
      end else begin
        next_byp = tdi_s;
      end
    end
    if (upd_en) begin
      next_bsr_upd = bsr_sh;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      bsr_sh <= '0;
      bsr_upd <= '0;
      id_sh <= '0;
      byp <= 1'h0;
    end else begin
      bsr_sh <= next_bsr_sh;
      bsr_upd <= next_bsr_upd;
      id_sh <= next_id_sh;
      byp <= next_byp;
    end
  end

  // ==========================================================================
  // Serial output
  // ==========================================================================
  logic next_tdo, next_tdo_oe_n;
  // TDO moves on the test clock fall, so the far end samples a stable bit.
  always_comb begin
    next_tdo = tdo_out;
    next_tdo_oe_n = tdo_oe_n_out;
    if (tck_fall) begin
      next_tdo_oe_n = !(tap == sjio_pkg::tap_shift_dr ||
                        tap == sjio_pkg::tap_shift_ir);
      if (tap == sjio_pkg::tap_shift_ir) begin
        next_tdo = ir_sh[0];
      end else if (sel_bsr) begin
        next_tdo = bsr_sh[0];
      end else if (sel_id) begin
        next_tdo = id_sh[0];
      end else begin
        next_tdo = byp;
      end
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tdo_out <= 1'h0;
      tdo_oe_n_out <= 1'h1;
    end else begin
      tdo_out <= next_tdo;
      tdo_oe_n_out <= next_tdo_oe_n;
    end
  end

  // ==========================================================================
  // Output pin control
  // ==========================================================================
  sjio_pkg::sjio_pins_t next_pins;
  logic next_echo_oe_n, next_q_oe_n;
  // Normal operation lets the SRAM drive data only while it reads.
  always_comb begin
    next_pins = sram_in;
    next_echo_oe_n = 1'h0;
    next_q_oe_n = !sram_read_in;
    if (ir == sjio_pkg::ins_extest) begin
      next_pins.echo = bsr_upd[sjio_pkg::ECHO_POS];
      next_pins.echo_n = bsr_upd[sjio_pkg::ECHO_N_POS];
      next_pins.q = bsr_upd[sjio_pkg::Q_POS +: sjio_pkg::DQ_W];
      next_q_oe_n = !bsr_upd[sjio_pkg::CTRL_POS];
    end else if (ir == sjio_pkg::ins_sample_z) begin
      next_echo_oe_n = 1'h1;
      next_q_oe_n = 1'h1;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pins_out <= '0;
      echo_oe_n_out <= 1'h0;
      q_oe_n_out <= 1'h1;
    end else begin
      pins_out <= next_pins;
      echo_oe_n_out <= next_echo_oe_n;
      q_oe_n_out <= next_q_oe_n;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_float_sample: assert property (
    ir == sjio_pkg::ins_sample_z |=> echo_oe_n_out && q_oe_n_out)
    else $error("Float-and-sample left a pin driven.");
  a_extest_data: assert property (
    ir == sjio_pkg::ins_extest |=>
      q_oe_n_out != $past(bsr_upd[sjio_pkg::CTRL_POS]))
    else $error("Data enable does not follow the control cell.");
  a_extest_echo: assert property (
    ir == sjio_pkg::ins_extest |=> !echo_oe_n_out &&
      pins_out.echo == $past(bsr_upd[sjio_pkg::ECHO_POS]))
    else $error("Echo clock not driven from update data.");
  a_normal_pass: assert property (
    ir inside {sjio_pkg::ins_idcode, sjio_pkg::ins_sample,
               sjio_pkg::ins_bypass} |=> pins_out == $past(sram_in))
    else $error("Normal SRAM output not passed through.");
  a_reset_idcode: assert property (
    tap == sjio_pkg::tap_reset |=> ir == sjio_pkg::ins_idcode)
    else $error("Test-Logic-Reset did not select identification.");
  a_ctrl_guard: assert property (
    $changed(bsr_upd[sjio_pkg::CTRL_POS]) |-> $past(upd_en))
    else $error("Control cell changed outside its update.");
  a_ir_update: assert property (
    tck_fall && tap == sjio_pkg::tap_upd_ir |=> ir == $past(ir_sh))
    else $error("Instruction not taken at Update-IR.");
  a_bypass_shift: assert property (
    tck_rise && tap == sjio_pkg::tap_shift_dr && !sel_bsr && !sel_id
      |=> byp == $past(tdi_s))
    else $error("Bypass bit did not take TDI.");
  a_sample_read: assert property (
    tck_rise && tap == sjio_pkg::tap_cap_dr && ir == sjio_pkg::ins_sample
      && sram_read_in |=>
      bsr_sh[sjio_pkg::Q_POS +: sjio_pkg::DQ_W] == $past(sram_in.q))
    else $error("Sample during read did not take internal data.");
  a_extest_pad: assert property (
    tck_rise && tap == sjio_pkg::tap_cap_dr && ir == sjio_pkg::ins_extest
      |=> bsr_sh[sjio_pkg::Q_POS +: sjio_pkg::DQ_W] == $past(pad_s.q))
    else $error("External test did not capture pad data.");
  a_id_capture: assert property (
    tck_rise && tap == sjio_pkg::tap_cap_dr && sel_id |=> id_sh == ID_VALUE)
    else $error("Identification value not captured.");
  c_float_sample: cover property (ir == sjio_pkg::ins_sample_z);
  c_extest_drive: cover property (
    ir == sjio_pkg::ins_extest && bsr_upd[sjio_pkg::CTRL_POS]);
  c_bypass_shift: cover property (
    tck_rise && tap == sjio_pkg::tap_shift_dr && ir == sjio_pkg::ins_bypass);

endmodule

// File: sjio_jtag_host.sv
// Behavioural board-level test controller driving the test access port.
`timescale 1ns/10ps
module sjio_jtag_host (
  // Test access port lines towards the device.
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out,
  // Test data coming back, already resolved with its pull-up.
  input wire logic tdo_in
);
  // ==========================================================================
  // Link timing and idle levels
  // ==========================================================================
  // Half of the 800 ns test clock period.
  localparam int HALF_NS = 400;
  // Select levels of an instruction load, first clock in bit 0.
  localparam logic [8:0] TMS_IR = 9'h0c3;

  // The test clock rests low between frames and only runs inside them.
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end

  // ==========================================================================
  // Frame tasks
  // ==========================================================================
  // One clock period. Lines change right after the falling edge; the answer
  // is read at the end of the high half, where it has long settled.
  task automatic cycle(input logic tms, input logic tdi, output logic tdo);
    tms_out = tms;
    tdi_out = tdi;
    #(HALF_NS);
    tck_out = 1'b1;
    #(HALF_NS);
    tdo = tdo_in;
    tck_out = 1'b0;
  endtask

  // Five clocks with select high reach test-logic reset from anywhere;
  // one more with it low parks the controller in idle. Data outside a
  // shift toggles so that no stale level passes for a driven one.
  task automatic reset_tap();
    logic t;
    #37;
    for (int i = 0; i < 6; i++) begin
      cycle(i < 5, !tdi_out, t);
    end
  endtask

  // Walks from idle to the instruction shift, sends the code lsb first and
  // returns to idle through the update state.
  task automatic load_ir(input logic [2:0] code);
    logic t;
    // The maker keeps this code for itself, so it is never sent.
    if (code == 3'h3) begin
      return;
    end
    #37;
    for (int i = 0; i < 9; i++) begin
      cycle(TMS_IR[i], (i >= 4 && i < 7) ? code[i-4] : !tdi_out, t);
    end
  endtask

  // Captures, shifts len bits lsb first while collecting the old contents,
  // then updates and returns to idle.
  task automatic scan_dr(input logic [127:0] din, input int len,
                         output logic [127:0] dout);
    logic t;
    dout = '0;
    #37;
    cycle(1'b1, !tdi_out, t);
    cycle(1'b0, !tdi_out, t);
    cycle(1'b0, !tdi_out, t);
    for (int i = 0; i < len; i++) begin
      cycle(i == len - 1, din[i], dout[i]);
    end
    cycle(1'b1, !tdi_out, t);
    cycle(1'b0, !tdi_out, t);
  endtask
endmodule

// File: test_sram_jtag_instruction_output_ctrl.sv
// Self-checking bench for the SRAM boundary-scan output control.
`timescale 1ns/10ps
module test_sram_jtag_instruction_output_ctrl;
  // ==========================================================================
  // Stimulus constants and signals
  // ==========================================================================
  localparam logic [31:0] ID_VAL = 32'h5c3a_96e1; // Arbitrary value.
  localparam logic [35:0] QX = 36'h3_c96a_5e17;
  localparam sjio_pkg::sjio_pins_t S_A = {1'b1, 1'b0, 36'h9_a5c3_0f1e};
  localparam sjio_pkg::sjio_pins_t P_A = {1'b0, 1'b1, 36'h6_5a3c_f0e1};
  // Pad values in scan chain order: echo, echo_n, then data.
  localparam logic [37:0] P_CH = {P_A.q, P_A.echo_n, P_A.echo};
  logic clk_in;
  logic rst_n_in;
  logic tck;
  logic tms;
  logic tdi;
  logic tdo_out;
  logic tdo_oe_n_out;
  logic tdo_line;
  logic sram_read_in;
  logic echo_oe_n_out;
  logic q_oe_n_out;
  logic [sjio_pkg::IN_W-1:0] in_pins_in;
  sjio_pkg::sjio_pins_t sram_in;
  sjio_pkg::sjio_pins_t pad_in;
  sjio_pkg::sjio_pins_t pins_out;
  logic [127:0] d;
  int n_errors;
  int checks_done;

  // The board pulls the test data line up while the device releases it.
  assign tdo_line = tdo_oe_n_out ? 1'b1 : tdo_out;

  // ==========================================================================
  // Device and controller
  // ==========================================================================
  sjio_ctrl #(.ID_VALUE(ID_VAL)) sjio_ctrl_inst (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .tck_in(tck), .tms_in(tms),
    .tdi_in(tdi), .tdo_out(tdo_out), .tdo_oe_n_out(tdo_oe_n_out),
    .sram_in(sram_in), .sram_read_in(sram_read_in), .pad_in(pad_in),
    .in_pins_in(in_pins_in), .pins_out(pins_out),
    .echo_oe_n_out(echo_oe_n_out), .q_oe_n_out(q_oe_n_out));
  sjio_jtag_host sjio_jtag_host_inst (
    .tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_line));

  // System clock of 100 ns.
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Compares one value and reports a mismatch at once.
  task automatic check(input string what, input logic [127:0] seen,
                       input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Prints the verdict and ends the run; also used by the watchdog.
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Core side changes just after an edge, then time for the pad syncs.
  task automatic set_core(input sjio_pkg::sjio_pins_t s,
                          input sjio_pkg::sjio_pins_t p, input logic rd);
    @(posedge clk_in);
    #1;
    sram_in = s;
    pad_in = p;
    sram_read_in = rd;
    repeat (4) @(posedge clk_in);
    #1;
  endtask

  // Boundary pattern: echo 0, echo_n 1, data q, control cell c.
  function automatic logic [127:0] mk(input logic [35:0] q, input logic c);
    logic [127:0] v;
    v = '0;
    v[1] = 1'b1;
    v[37:2] = q;
    v[109] = c;
    return v;
  endfunction

  // Normal mode: pins follow the core, echo pair driven, data on read only.
  task automatic check_normal();
    for (int r = 0; r < 2; r++) begin
      set_core(S_A, P_A, r[0]);
      check("pins", 128'(pins_out), 128'(S_A));
      check("echo_oe_n", 128'(echo_oe_n_out), 128'h0);
      check("q_oe_n", 128'(q_oe_n_out), 128'(!r[0]));
    end
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  // Identification holds after reset and again after a test-logic reset.
  task automatic t_idcode();
    sjio_jtag_host_inst.reset_tap();
    check_normal();
    sjio_jtag_host_inst.scan_dr('0, 32, d);
    check("id after reset", 128'(d[31:0]), 128'(ID_VAL));
    sjio_jtag_host_inst.load_ir(3'h7);
    sjio_jtag_host_inst.reset_tap();
    sjio_jtag_host_inst.scan_dr('0, 32, d);
    check("id after tap reset", 128'(d[31:0]), 128'(ID_VAL));
  endtask

  // Bypass and both reserved codes give a one-bit path behind a zero.
  task automatic t_bypass();
    logic [2:0] codes [3];
    codes = '{3'h7, 3'h5, 3'h6};
    foreach (codes[k]) begin
      sjio_jtag_host_inst.load_ir(codes[k]);
      check_normal();
      sjio_jtag_host_inst.scan_dr(128'hb2, 9, d);
      check("bypass", 128'(d[8:0]), 128'({8'hb2, 1'b0}));
    end
  endtask

  // Sample takes the core echo pair, core data on read and pad data when idle; it also preloads.
  task automatic t_sample();
    sjio_jtag_host_inst.load_ir(3'h4);
    check_normal();
    for (int r = 1; r >= 0; r--) begin
      set_core(S_A, P_A, r[0]);
      sjio_jtag_host_inst.scan_dr(mk(QX, 1'b1), 110, d);
      check("smp echo", 128'(d[1:0]), 128'({S_A.echo_n, S_A.echo}));
      check("smp q", 128'(d[37:2]), 128'(r ? S_A.q : P_A.q));
      check("smp pins", 128'(pins_out), 128'(S_A));
    end
  endtask

  // External test drives the update bits; data enable follows bit 109.
  task automatic t_extest();
    sjio_jtag_host_inst.load_ir(3'h0);
    check("ext pins", 128'(pins_out), 128'({1'b0, 1'b1, QX}));
    check("ext q_oe_n", 128'(q_oe_n_out), 128'h0);
    for (int r = 0; r < 2; r++) begin
      set_core(S_A, P_A, r[0]);
      sjio_jtag_host_inst.scan_dr(mk(QX, r[0]), 110, d);
      check("ext capture", 128'(d[37:0]), 128'(P_CH));
      check("ext echo_oe_n", 128'(echo_oe_n_out), 128'h0);
      check("ext q_oe_n", 128'(q_oe_n_out), 128'(!r[0]));
    end
  endtask

  // Float-and-sample releases all outputs and takes pads, while its scans
  // must leave the update bits and the control cell untouched.
  task automatic t_float();
    sjio_jtag_host_inst.load_ir(3'h2);
    for (int r = 0; r < 2; r++) begin
      set_core(S_A, P_A, r[0]);
      check("flt echo_oe_n", 128'(echo_oe_n_out), 128'h1);
      check("flt q_oe_n", 128'(q_oe_n_out), 128'h1);
      sjio_jtag_host_inst.scan_dr(mk(~QX, 1'b0), 110, d);
      check("flt capture", 128'(d[37:0]), 128'(P_CH));
    end
    sjio_jtag_host_inst.load_ir(3'h0);
    check("kept q", 128'(pins_out.q), 128'(QX));
    check("kept control", 128'(q_oe_n_out), 128'h0);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  // Reset for 12 clocks, then the scenarios in an order that chains state.
  initial begin
    rst_n_in = 1'b0;
    sram_in = S_A;
    pad_in = P_A;
    sram_read_in = 1'b0;
    in_pins_in = 71'h2a_5a5a_5a5a_5a5a_5a5a;
    n_errors = 0;
    checks_done = 0;
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    repeat (4) @(posedge clk_in);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_float();
    close_out();
  end

  // A hung run counts as a mismatch and goes to the closing report.
  initial begin
    repeat (60000) @(posedge clk_in);
    n_errors++;
    close_out();
  end
endmodule
